// file: core/mac_pkg.sv
// package for the multiply accumulate engine: widths, op codes, state layout
// assumes a single core clock and a synchronous active-high reset
package mac_pkg;

    localparam int OPW       = 16;
    localparam int ACCW      = 40;
    localparam int PRODW     = 32;
    // fractional operands are Q15: product shifted left one place
    localparam int FRAC_SHIFT = 1;
    // rounding point of the Q15 result inside the accumulator
    localparam int RND_LSB   = 16;
    localparam logic [ACCW-1:0] ACC_RESET = 40'h00_0000_0000;
    localparam logic [OPW-1:0]  RND_RESET = 16'h0000;

    // command codes presented on the request port
    typedef enum logic [2:0] {
        CMD_NOP   = 3'h0,
        CMD_MUL   = 3'h1,
        CMD_MAC   = 3'h2,
        CMD_SHL   = 3'h3,
        CMD_SHR   = 3'h4,
        CMD_CLR   = 3'h5
    } cmd_t;

    typedef struct packed {
        logic              valid;
        cmd_t              cmd;
        logic              frac;
        logic [OPW-1:0]    op_a;
        logic [OPW-1:0]    op_b;
    } req_t;

    typedef struct packed {
        logic              acc_done;
        logic              rnd_done;
        logic [ACCW-1:0]   acc;
        logic [OPW-1:0]    rnd;
    } res_t;

    // whole engine state in one record
    typedef struct packed {
        logic              s1_valid;
        logic              s1_acc_mode;
        logic [ACCW-1:0]   s1_prod;
        logic              s2_valid;
        logic [ACCW-1:0]   acc;
        logic              acc_done;
        logic              rnd_done;
        logic [OPW-1:0]    rnd;
    } state_t;

endpackage

// file: core/mult_acc_unit.sv
// multiply accumulate engine: signed 16x16 multiply, 40-bit accumulator, rounding, shifter
// assumes requests arrive synchronous to mclk; one request may be issued per cycle
// assumes shifts and clears come at least one idle cycle after a multiply; one that
// meets the add stage is dropped
// the rounded result follows multiplies only; a shift leaves it as it was
//
// Contract
// - signed 16x16 multiply, full precision product
// - integer/fractional, mul/mac, done in two cycles
// - rounded 16-bit fractional result in third cycle
// - one-bit accumulator shift in one cycle
module mult_acc_unit (
    input  wire logic          mclk,
    input  wire logic          srst,
    input  wire mac_pkg::req_t req,
    output mac_pkg::res_t      res
);

    mac_pkg::state_t cur_ff;
    mac_pkg::state_t nxt_cur;

    // ****************************************
    // arithmetic helpers
    // ****************************************
    // multiply and accumulate share the multiplier and the two-stage path
    function automatic logic is_arith(
        input mac_pkg::cmd_t cmd
    );
        return (cmd == mac_pkg::CMD_MUL) || (cmd == mac_pkg::CMD_MAC);
    endfunction

    function automatic logic [mac_pkg::ACCW-1:0] product(
        input logic [mac_pkg::OPW-1:0] a,
        input logic [mac_pkg::OPW-1:0] b,
        input logic                    frac
    );
        logic signed [mac_pkg::PRODW-1:0] p;
        logic signed [mac_pkg::ACCW-1:0]  w;
        p = $signed(a) * $signed(b);
        w = mac_pkg::ACCW'(p);
        // q15 times q15 is q30; one more place aligns the sign with bit 31
        if (frac) begin
            w = w <<< mac_pkg::FRAC_SHIFT;
        end
        return w;
    endfunction

    // round half up on the Q15 field of the accumulator; no saturation, so a value
    // beyond the Q15 range wraps in the rounded result
    function automatic logic [mac_pkg::OPW-1:0] round_q15(
        input logic [mac_pkg::ACCW-1:0] acc
    );
        logic [mac_pkg::ACCW-1:0] t;
        t = acc + (mac_pkg::ACCW'(1) << (mac_pkg::RND_LSB - 1));
        return t[mac_pkg::RND_LSB +: mac_pkg::OPW];
    endfunction

    // ****************************************
    // next state
    // ****************************************
    // timing, counted from the edge that takes a request:
    //   mul/mac: that edge registers the product, the next one updates the accumulator
    //            and raises acc_done, the one after that registers the rounded result
    //   shl/shr/clr: the taking edge updates the accumulator and raises acc_done
    // the product is formed every cycle and only s1_valid qualifies it; gating the
    // operands would cost a mux on the slowest path for no gain
    always_comb begin
        nxt_cur          = cur_ff;
        // done flags are pulses: cleared here, set below by the stage that finishes
        nxt_cur.acc_done = 1'b0;
        nxt_cur.rnd_done = 1'b0;
        // stage 1: multiply
        nxt_cur.s1_valid    = req.valid && is_arith(req.cmd);
        nxt_cur.s1_acc_mode = (req.cmd == mac_pkg::CMD_MAC);
        nxt_cur.s1_prod     = product(req.op_a, req.op_b, req.frac);
        // stage 2: add or load into accumulator
        // the adder owns the accumulator in this cycle, so a shift or clear taken now
        // is dropped rather than queued: no buffer and no stall
        if (cur_ff.s1_valid) begin
            if (cur_ff.s1_acc_mode) begin
                nxt_cur.acc = cur_ff.acc + cur_ff.s1_prod;
            end else begin
                nxt_cur.acc = cur_ff.s1_prod;
            end
            nxt_cur.acc_done = 1'b1;
        end else if (req.valid) begin
            // shifts and clear act on the settled accumulator in one cycle
            unique case (req.cmd)
                mac_pkg::CMD_SHL: begin
                    nxt_cur.acc      = {cur_ff.acc[mac_pkg::ACCW-2:0], 1'b0};
                    nxt_cur.acc_done = 1'b1;
                end
                mac_pkg::CMD_SHR: begin
                    nxt_cur.acc = {cur_ff.acc[mac_pkg::ACCW-1],
                                   cur_ff.acc[mac_pkg::ACCW-1:1]};
                    nxt_cur.acc_done = 1'b1;
                end
                mac_pkg::CMD_CLR: begin
                    nxt_cur.acc      = mac_pkg::ACC_RESET;
                    nxt_cur.acc_done = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // stage 3: rounding follows a multiply result by one cycle
        // shifts do not re-round, which keeps the rounder off the shifter's path
        nxt_cur.s2_valid = cur_ff.s1_valid;
        if (cur_ff.s2_valid) begin
            nxt_cur.rnd      = round_q15(cur_ff.acc);
            nxt_cur.rnd_done = 1'b1;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk) begin
        // the whole record resets so no field carries an unknown into the first add
        if (srst) begin
            cur_ff <= '{s1_valid: 1'b0, s1_acc_mode: 1'b0, s1_prod: mac_pkg::ACC_RESET,
                        s2_valid: 1'b0, acc: mac_pkg::ACC_RESET, acc_done: 1'b0,
                        rnd_done: 1'b0, rnd: mac_pkg::RND_RESET};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // every output is a field of the state register
    assign res = '{acc_done: cur_ff.acc_done, rnd_done: cur_ff.rnd_done,
                   acc: cur_ff.acc, rnd: cur_ff.rnd};

    // ****************************************
    // checks
    // ****************************************
    // the checks watch the outputs where they can, so that a broken register path shows,
    // and use the stage flags to time the add, load and hold checks and to tell a dropped command from a taken one
    a_mul_two_cycles: assert property (@(posedge mclk) disable iff (srst)
        req.valid && req.cmd == mac_pkg::CMD_MUL |-> ##2 res.acc_done &&
        res.acc == product($past(req.op_a, 2), $past(req.op_b, 2), $past(req.frac, 2)))
        else $error("multiply result not loaded two cycles later");

    a_mac_adds_prod: assert property (@(posedge mclk) disable iff (srst)
        cur_ff.s1_valid && cur_ff.s1_acc_mode |=>
        res.acc == $past(cur_ff.acc) + $past(cur_ff.s1_prod))
        else $error("accumulate did not add product");

    a_int_product: assert property (@(posedge mclk) disable iff (srst)
        req.valid && req.cmd == mac_pkg::CMD_MUL && !req.frac |=>
        $signed(cur_ff.s1_prod) == $signed($past(req.op_a)) * $signed($past(req.op_b)))
        else $error("integer product wrong");

    a_round_third: assert property (@(posedge mclk) disable iff (srst)
        req.valid && is_arith(req.cmd)
        |-> ##2 res.acc_done ##1 res.rnd_done && res.rnd == round_q15($past(res.acc)))
        else $error("rounded result missing in third cycle");

    a_shift_left: assert property (@(posedge mclk) disable iff (srst)
        req.valid && req.cmd == mac_pkg::CMD_SHL && !cur_ff.s1_valid |=>
        res.acc_done && res.acc == {$past(cur_ff.acc[mac_pkg::ACCW-2:0]), 1'b0})
        else $error("left shift wrong");

    a_shift_sign: assert property (@(posedge mclk) disable iff (srst)
        req.valid && req.cmd == mac_pkg::CMD_SHR && !cur_ff.s1_valid |=>
        res.acc[mac_pkg::ACCW-1] == res.acc[mac_pkg::ACCW-2] &&
        res.acc[mac_pkg::ACCW-2:0] == $past(cur_ff.acc[mac_pkg::ACCW-1:1]))
        else $error("right shift lost sign");

    a_no_rnd_idle: assert property (@(posedge mclk) disable iff (srst)
        res.rnd_done |-> $past(res.acc_done))
        else $error("rounding done without multiply");

    a_acc_hold: assert property (@(posedge mclk) disable iff (srst)
        !req.valid && !cur_ff.s1_valid |=> $stable(res.acc))
        else $error("accumulator changed while idle");

    a_mac_two_cycles: assert property (@(posedge mclk) disable iff (srst)
        req.valid && req.cmd == mac_pkg::CMD_MAC |-> ##2 res.acc_done &&
        res.acc == $past(res.acc) + product($past(req.op_a, 2), $past(req.op_b, 2),
                                            $past(req.frac, 2)))
        else $error("accumulate result not ready two cycles later");

    a_frac_product: assert property (@(posedge mclk) disable iff (srst)
        req.valid && is_arith(req.cmd) && req.frac |=>
        $signed(cur_ff.s1_prod) ==
            (($signed($past(req.op_a)) * $signed($past(req.op_b))) <<< mac_pkg::FRAC_SHIFT))
        else $error("fractional product not aligned");

    a_mul_loads: assert property (@(posedge mclk) disable iff (srst)
        cur_ff.s1_valid && !cur_ff.s1_acc_mode |=> res.acc == $past(cur_ff.s1_prod))
        else $error("multiply did not load product");

    a_shr_done: assert property (@(posedge mclk) disable iff (srst)
        req.valid && req.cmd == mac_pkg::CMD_SHR && !cur_ff.s1_valid |=> res.acc_done)
        else $error("right shift took more than one cycle");

    a_shl_zero_in: assert property (@(posedge mclk) disable iff (srst)
        req.valid && req.cmd == mac_pkg::CMD_SHL && !cur_ff.s1_valid |=> !res.acc[0])
        else $error("left shift did not fill zero");

    a_clear_zero: assert property (@(posedge mclk) disable iff (srst)
        req.valid && req.cmd == mac_pkg::CMD_CLR && !cur_ff.s1_valid |=>
        res.acc_done && res.acc == mac_pkg::ACC_RESET)
        else $error("clear did not empty accumulator");

    a_nop_quiet: assert property (@(posedge mclk) disable iff (srst)
        (!req.valid || req.cmd == mac_pkg::CMD_NOP) && !cur_ff.s1_valid |=> !res.acc_done)
        else $error("accumulator done on an idle cycle");

    a_done_cause: assert property (@(posedge mclk) disable iff (srst)
        res.acc_done |-> $past(cur_ff.s1_valid) || ($past(req.valid) &&
        !is_arith($past(req.cmd)) && $past(req.cmd) != mac_pkg::CMD_NOP))
        else $error("accumulator done without a command");

    a_rnd_hold: assert property (@(posedge mclk) disable iff (srst)
        !cur_ff.s2_valid |=> $stable(res.rnd))
        else $error("rounded result changed without a multiply");

    a_rnd_value: assert property (@(posedge mclk) disable iff (srst)
        res.rnd_done |-> res.rnd == round_q15($past(res.acc)))
        else $error("rounded result does not match accumulator");

endmodule

// file: testbench/mult_acc_unit_tb.sv
// self-checking bench for the multiply accumulate engine
// assumes mac_pkg is compiled first; bench drives req itself, no partner model
module mult_acc_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic              mclk;
    logic              srst;
    mac_pkg::req_t     req;
    mac_pkg::res_t     res;
    logic [39:0]       exp_acc;
    logic [15:0]       exp_rnd;
    logic [31:0]       seed;
    int                n_errors;
    int                check_count;
    int                cycles;

    mult_acc_unit u_dut (.mclk(mclk), .srst(srst), .req(req), .res(res));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ********************
    // helpers
    // ********************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [39:0] prod(input logic f, input logic [15:0] a, b);
        logic signed [39:0] p;
        p = $signed(a) * $signed(b);
        return f ? p <<< 1 : p;
    endfunction

    function automatic logic [15:0] rnd_of(input logic [39:0] a);
        logic [39:0] t;
        t = a + 40'h00_0000_8000;
        return t[31:16];
    endfunction

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // nop waits like a multiply so a stray done pulse would be seen
    task automatic do_op(input mac_pkg::cmd_t c, input logic f, input logic [15:0] a, b);
        logic arith;
        arith = (c == mac_pkg::CMD_MUL) || (c == mac_pkg::CMD_MAC);
        case (c)
            mac_pkg::CMD_MUL: exp_acc = prod(f, a, b);
            mac_pkg::CMD_MAC: exp_acc = exp_acc + prod(f, a, b);
            mac_pkg::CMD_SHL: exp_acc = exp_acc << 1;
            mac_pkg::CMD_SHR: exp_acc = $signed(exp_acc) >>> 1;
            mac_pkg::CMD_CLR: exp_acc = 40'h00_0000_0000;
            default: ;
        endcase
        @(posedge mclk) req <= '{1'b1, c, f, a, b};
        @(posedge mclk) req.valid <= 1'b0;
        repeat ((arith || c == mac_pkg::CMD_NOP) ? 1 : 0) @(posedge mclk);
        @(negedge mclk);
        check(40'(res.acc_done), 40'(c != mac_pkg::CMD_NOP));
        check(res.acc, exp_acc);
        if (arith) begin
            exp_rnd = rnd_of(exp_acc);
            @(negedge mclk);
            check(40'(res.rnd_done), 40'h1);
            check(40'(res.rnd), 40'(exp_rnd));
        end
    endtask

    // two accumulates taken on consecutive edges
    task automatic do_mac2(input logic f, input logic [31:0] x, y);
        logic [39:0] mid;
        mid = exp_acc + prod(f, x[31:16], x[15:0]);
        exp_acc = mid + prod(f, y[31:16], y[15:0]);
        @(posedge mclk) req <= '{1'b1, mac_pkg::CMD_MAC, f, x[31:16], x[15:0]};
        @(posedge mclk) req <= '{1'b1, mac_pkg::CMD_MAC, f, y[31:16], y[15:0]};
        @(posedge mclk) req.valid <= 1'b0;
        @(negedge mclk);
        check(res.acc, mid);
        @(negedge mclk);
        check(res.acc, exp_acc);
        check(40'(res.acc_done), 40'h1);
        check(40'(res.rnd), 40'(rnd_of(mid)));
        @(negedge mclk);
        check(40'(res.rnd_done), 40'h1);
        check(40'(res.rnd), 40'(rnd_of(exp_acc)));
    endtask

    // ********************
    // main sequence
    // ********************
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        req = '0;
        srst = 1'b1;
        seed = 32'h07882AD6;
        exp_acc = 40'h00_0000_0000;
        exp_rnd = 16'h0000;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        check(res.acc, 40'h00_0000_0000);
        check(40'(res.rnd), 40'h0);
        do_op(mac_pkg::CMD_MUL, 1'b1, 16'h8000, 16'h8000);
        do_op(mac_pkg::CMD_MAC, 1'b0, 16'h7FFF, 16'h8000);
        do_op(mac_pkg::CMD_SHR, 1'b0, 16'h0000, 16'h0000);
        do_op(mac_pkg::CMD_SHL, 1'b0, 16'h0000, 16'h0000);
        do_op(mac_pkg::CMD_NOP, 1'b0, 16'h1234, 16'h5678);
        do_op(mac_pkg::CMD_CLR, 1'b0, 16'h0000, 16'h0000);
        for (int i = 0; i < 80; i++) begin
            seed = lfsr(seed);
            do_op(mac_pkg::cmd_t'(seed[2:0] % 3'h6), seed[3], seed[31:16], seed[19:4]);
        end
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            do_mac2(seed[0], seed, lfsr(seed) ^ 32'h5A5A_A5A5);
        end
        // mid-run reset: accumulator and rounded result must both clear
        do_op(mac_pkg::CMD_MAC, 1'b0, 16'h4000, 16'h4000);
        @(posedge mclk) srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(negedge mclk);
        check(res.acc, 40'h00_0000_0000);
        check(40'(res.rnd), 40'h0);
        check(40'(res.acc_done), 40'h0);
        exp_acc = 40'h00_0000_0000;
        do_op(mac_pkg::CMD_MAC, 1'b1, 16'h4000, 16'hC000);
        finish_test();
    end
endmodule
